// File: common/mmd_pkg.sv
// package for the memory map decoder: address map, region codes, port layout
// assumes 14-bit cpu addresses and 8-bit data
package mmd_pkg;
  localparam int MMD_AW = 14;
  localparam int MMD_DW = 8;
  localparam int MMD_RAM_BYTES = 176;
  localparam int MMD_RAM_AW = 8;
  localparam logic [13:0] MMD_IO_LO = 14'h0000;
  localparam logic [13:0] MMD_IO_HI = 14'h001f;
  localparam logic [13:0] MMD_PZ_LO = 14'h0020;
  localparam logic [13:0] MMD_PZ_HI = 14'h004f;
  localparam logic [13:0] MMD_RAM_LO = 14'h0050;
  localparam logic [13:0] MMD_RAM_HI = 14'h00ff;
  localparam logic [13:0] MMD_ROM_LO = 14'h1000;
  localparam logic [13:0] MMD_ROM_HI = 14'h3eff;
  localparam logic [13:0] MMD_SC_LO = 14'h3f00;
  localparam logic [13:0] MMD_SC_HI = 14'h3fef;
  localparam logic [13:0] MMD_VEC_LO = 14'h3ff0;
  localparam logic [13:0] MMD_VEC_HI = 14'h3fff;
  localparam logic [13:0] MMD_VUSED_LO = 14'h3ff4;
  localparam logic [13:0] MMD_STK_TOP = 14'h00ff;
  localparam logic [13:0] MMD_STK_BOT = 14'h00c0;
  localparam logic [5:0] MMD_SP_RESET = 6'h3f;
  localparam logic [13:0] MMD_DDR_LO = 14'h0004;
  localparam logic [13:0] MMD_PORTD_ADDR = 14'h0003;
  localparam logic [7:0] MMD_PORTD_MASK = 8'hbf;
  localparam logic [7:0] MMD_DDR_RESET = 8'h00;

  typedef enum logic [2:0] {
    MMD_SEL_NONE = 3'b000,
    MMD_SEL_IO = 3'b001,
    MMD_SEL_PZROM = 3'b010,
    MMD_SEL_RAM = 3'b011,
    MMD_SEL_ROM = 3'b100,
    MMD_SEL_SCROM = 3'b101,
    MMD_SEL_VEC = 3'b110
  } mmd_sel_t;

  typedef struct packed {
    logic irq_level; // 1: edge and level
    logic clk_rc; // 1: rc clocking
    logic watchdog_option; // 1: watchdog enabled
    logic stop_en; // 1: stop instruction enabled
  } mmd_opt_t;

  typedef struct packed {
    logic [13:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } mmd_bus_t;
endpackage

// File: hw/mmd_ram.sv
// user ram, registered read data
// assumes one access per cycle from the decoder
`timescale 1ns/100ps
`default_nettype none
module mmd_ram
  import mmd_pkg::*;
#(
  parameter int DEPTH = MMD_RAM_BYTES,
  parameter int AW = MMD_RAM_AW
)
(
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  if (DEPTH < 1 || DEPTH > (1 << AW))
  begin : g_depth_check
    $error("ram depth exceeds address width");
  end
  logic [7:0] mem [DEPTH];
  always_ff @(posedge ref_clk)
  begin
    if (we && 32'(addr) < DEPTH)
    begin
      mem[addr] <= wdata;
    end
    rdata <= (32'(addr) < DEPTH) ? mem[addr] : 8'h00;
  end
endmodule // mmd_ram
`default_nettype wire

// File: hw/mmd_top.sv
// memory map decoder: region select, ram, port direction and options
// assumes the cpu core drives a synchronous bus at ref_clk
`timescale 1ns/100ps
`default_nettype none
module mmd_top
  import mmd_pkg::*;
#(
  parameter logic [7:0] PULLUP_IRQ_OPTION = 8'h00,
  parameter mmd_opt_t FIXED_OPTIONS = 4'h0
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reset_n,
  input wire logic oscillator_input,
  input wire mmd_bus_t cpu_bus,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic [7:0] first_bidir_port_in,
  input wire logic [7:0] second_bidir_port_in,
  input wire logic [7:0] third_bidir_port_in,
  input wire logic [7:0] input_only_port,
  output logic [2:0] region_sel,
  output logic rom_sel,
  output logic vector_hit,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic [13:0] stack_addr,
  output logic bus_clk,
  output logic [7:0] first_bidir_port_out,
  output logic [7:0] first_bidir_port_oe,
  output logic [7:0] second_bidir_port_out,
  output logic [7:0] second_bidir_port_oe,
  output logic [7:0] third_bidir_port_out,
  output logic [7:0] third_bidir_port_oe,
  output logic [7:0] second_port_pullup_en,
  output logic [7:0] second_port_irq_en,
  output logic [1:0] async_serial_iface_pins,
  output logic [3:0] spi_pins,
  output logic input_only_line_seven,
  output mmd_opt_t options
);
  function automatic mmd_sel_t decode(input logic [13:0] a);
    if (a <= MMD_IO_HI) return MMD_SEL_IO;
    if (a >= MMD_PZ_LO && a <= MMD_PZ_HI) return MMD_SEL_PZROM;
    if (a >= MMD_RAM_LO && a <= MMD_RAM_HI) return MMD_SEL_RAM;
    if (a >= MMD_ROM_LO && a <= MMD_ROM_HI) return MMD_SEL_ROM;
    if (a >= MMD_SC_LO && a <= MMD_SC_HI) return MMD_SEL_SCROM;
    if (a >= MMD_VEC_LO) return MMD_SEL_VEC;
    return MMD_SEL_NONE;
  endfunction

  logic rst;
  mmd_sel_t sel;
  logic [7:0] ddr [3];
  logic [7:0] dat [3];
  logic [7:0] next_ddr [3];
  logic [7:0] next_dat [3];
  logic [5:0] sp;
  logic [5:0] next_sp;
  logic clk_div;
  logic next_clk_div;
  logic osc_prev;
  logic osc_edge;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic [13:0] ram_off;
  logic read_done;
  logic next_read_done;
  logic ram_read;
  logic next_ram_read;
  logic [7:0] io_rdata;
  logic [7:0] next_io_rdata;

  assign rst = sys_rst | ~reset_n;
  assign sel = decode(cpu_bus.addr);
  assign region_sel = sel;
  assign rom_sel = (sel == MMD_SEL_PZROM) || (sel == MMD_SEL_ROM) || (sel == MMD_SEL_VEC);
  assign vector_hit = (sel == MMD_SEL_VEC) && (cpu_bus.addr >= MMD_VUSED_LO);

  io_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr <= MMD_IO_HI) |-> sel == MMD_SEL_IO && !rom_sel)
    else $error("io block not selected");
  ram_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr >= MMD_RAM_LO && cpu_bus.addr <= MMD_RAM_HI) |-> sel == MMD_SEL_RAM && !rom_sel)
    else $error("user ram not selected");
  vec_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr >= MMD_VEC_LO) |-> sel == MMD_SEL_VEC && rom_sel)
    else $error("vector region not selected");
  vec_used_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr >= MMD_VUSED_LO) |-> vector_hit)
    else $error("used vector not flagged");
  gap_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr > MMD_RAM_HI && cpu_bus.addr < MMD_ROM_LO) |-> sel == MMD_SEL_NONE && !rom_sel)
    else $error("unmapped address selected");

  // ram, writes only when selected
  assign ram_off = cpu_bus.addr - MMD_RAM_LO;
  assign ram_we = cpu_bus.wr && (sel == MMD_SEL_RAM);
  mmd_ram #(.DEPTH(MMD_RAM_BYTES), .AW(MMD_RAM_AW)) u_ram (
    .ref_clk(ref_clk),
    .we(ram_we),
    .addr(ram_off[7:0]),
    .wdata(cpu_bus.wdata),
    .rdata(ram_rdata)
  );

  // port data and direction registers
  always_comb
  begin
    next_io_rdata = 8'h00;
    next_read_done = cpu_bus.rd && (sel == MMD_SEL_RAM || sel == MMD_SEL_IO);
    next_ram_read = sel == MMD_SEL_RAM;
    for (int i = 0; i < 3; i++)
    begin
      next_ddr[i] = ddr[i];
      next_dat[i] = dat[i];
      if (cpu_bus.wr && cpu_bus.addr == MMD_IO_LO + 14'(i))
      begin
        next_dat[i] = cpu_bus.wdata;
      end
      if (cpu_bus.wr && cpu_bus.addr == MMD_DDR_LO + 14'(i))
      begin
        next_ddr[i] = cpu_bus.wdata;
      end
    end
    unique case (cpu_bus.addr)
      MMD_IO_LO: next_io_rdata = (ddr[0] & dat[0]) | (~ddr[0] & first_bidir_port_in);
      MMD_IO_LO + 14'h0001: next_io_rdata = (ddr[1] & dat[1]) | (~ddr[1] & second_bidir_port_in);
      MMD_IO_LO + 14'h0002: next_io_rdata = (ddr[2] & dat[2]) | (~ddr[2] & third_bidir_port_in);
      MMD_PORTD_ADDR: next_io_rdata = input_only_port & MMD_PORTD_MASK;
      MMD_DDR_LO: next_io_rdata = ddr[0];
      MMD_DDR_LO + 14'h0001: next_io_rdata = ddr[1];
      MMD_DDR_LO + 14'h0002: next_io_rdata = ddr[2];
      default: next_io_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < 3; i++)
      begin
        ddr[i] <= MMD_DDR_RESET;
        dat[i] <= 8'h00;
      end
      io_rdata <= 8'h00;
      read_done <= 1'b0;
      ram_read <= 1'b0;
    end
    else
    begin
      ddr <= next_ddr;
      dat <= next_dat;
      io_rdata <= next_io_rdata;
      read_done <= next_read_done;
      ram_read <= next_ram_read;
    end
  end

  assign rdata = ram_read ? ram_rdata : io_rdata;
  assign rdata_valid = read_done;

  read_valid_a: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_bus.rd && (sel == MMD_SEL_RAM || sel == MMD_SEL_IO) |=> rdata_valid)
    else $error("read not answered");
  read_none_a: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_bus.rd && sel == MMD_SEL_NONE |=> !rdata_valid)
    else $error("unmapped read answered");
  ddr_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_bus.wr && cpu_bus.addr == MMD_DDR_LO |=> first_bidir_port_oe == $past(cpu_bus.wdata))
    else $error("direction write lost");
  port_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_bus.rd && !cpu_bus.wr && cpu_bus.addr == MMD_IO_LO
    |=> rdata == (($past(first_bidir_port_oe) & $past(first_bidir_port_out))
    | (~$past(first_bidir_port_oe) & $past(first_bidir_port_in))))
    else $error("port read wrong");
  portd_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    cpu_bus.rd && cpu_bus.addr == MMD_PORTD_ADDR |=> rdata == ($past(input_only_port) & MMD_PORTD_MASK))
    else $error("input-only port read wrong");

  assign first_bidir_port_out = dat[0];
  assign first_bidir_port_oe = ddr[0];
  assign second_bidir_port_out = dat[1];
  assign second_bidir_port_oe = ddr[1];
  assign third_bidir_port_out = dat[2];
  assign third_bidir_port_oe = ddr[2];
  assign second_port_pullup_en = PULLUP_IRQ_OPTION;
  assign second_port_irq_en = PULLUP_IRQ_OPTION;
  assign async_serial_iface_pins = input_only_port[1:0];
  assign spi_pins = input_only_port[5:2];
  assign input_only_line_seven = input_only_port[7];
  assign options = FIXED_OPTIONS;

  pullup_irq_a: assert property (@(posedge ref_clk) disable iff (rst)
    second_port_pullup_en == second_port_irq_en)
    else $error("pullup and interrupt enables differ");

  // stack pointer, six bits offset into 00C0..00FF
  always_comb
  begin
    next_sp = sp;
    if (sp_push && !sp_pop)
    begin
      next_sp = sp - 6'h01;
    end
    else if (sp_pop && !sp_push)
    begin
      next_sp = sp + 6'h01;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sp <= MMD_SP_RESET;
    end
    else
    begin
      sp <= next_sp;
    end
  end

  assign stack_addr = MMD_STK_BOT | {8'h00, sp};

  sp_push_a: assert property (@(posedge ref_clk) disable iff (rst)
    sp_push && !sp_pop |=> sp == $past(sp) - 6'h01)
    else $error("push did not move stack down");
  sp_pop_a: assert property (@(posedge ref_clk) disable iff (rst)
    sp_pop && !sp_push |=> sp == $past(sp) + 6'h01)
    else $error("pop did not move stack up");
  sp_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    sp_push == sp_pop |=> $stable(sp))
    else $error("stack moved without a strobe");

  // bus clock toggles on each oscillator rising edge
  assign osc_edge = oscillator_input & ~osc_prev;
  always_comb
  begin
    next_clk_div = clk_div;
    if (osc_edge)
    begin
      next_clk_div = ~clk_div;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      osc_prev <= 1'b0;
      clk_div <= 1'b0;
    end
    else
    begin
      osc_prev <= oscillator_input;
      clk_div <= next_clk_div;
    end
  end

  assign bus_clk = clk_div;

  ram_unmapped_a: assert property (@(posedge ref_clk) disable iff (rst)
    (sel != MMD_SEL_RAM) |-> !ram_we) else $error("ram write outside ram");
  vec_unused_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr < MMD_VUSED_LO) |-> !vector_hit) else $error("vector hit below 3ff4");
  pz_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr >= MMD_PZ_LO && cpu_bus.addr <= MMD_PZ_HI) |-> sel == MMD_SEL_PZROM)
    else $error("page zero rom not selected");
  rom_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr >= MMD_ROM_LO && cpu_bus.addr <= MMD_ROM_HI) |-> rom_sel && sel == MMD_SEL_ROM)
    else $error("main rom not selected");
  sc_select_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_bus.addr >= MMD_SC_LO && cpu_bus.addr <= MMD_SC_HI) |-> sel == MMD_SEL_SCROM)
    else $error("self-check rom not selected");
  stack_range_a: assert property (@(posedge ref_clk) disable iff (rst)
    stack_addr >= MMD_STK_BOT && stack_addr <= MMD_STK_TOP) else $error("stack out of range");
  ddr_reset_a: assert property (@(posedge ref_clk)
    $past(rst) |-> first_bidir_port_oe == 8'h00 && second_bidir_port_oe == 8'h00
    && third_bidir_port_oe == 8'h00) else $error("port not input after reset");
  sp_reset_a: assert property (@(posedge ref_clk)
    $past(rst) |-> stack_addr == MMD_STK_TOP) else $error("stack not at top after reset");
  bus_clk_a: assert property (@(posedge ref_clk) disable iff (rst)
    $past(osc_edge) && !$past(rst) |-> bus_clk != $past(bus_clk)) else $error("bus clock missed osc edge");
  bus_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(osc_edge) && !$past(rst) |-> $stable(bus_clk)) else $error("bus clock moved");
  portd_six_a: assert property (@(posedge ref_clk) disable iff (rst)
    $past(cpu_bus.addr == MMD_PORTD_ADDR) && !$past(rst) |-> !io_rdata[6])
    else $error("input-only line six read set");
endmodule // mmd_top
`default_nettype wire

// File: verif/mmd_cpu_model.sv
// cpu core model: bus accesses, stack strobes, external reset
// assumes inputs change at the falling edge of ref_clk
`timescale 1ns/100ps
`default_nettype none
module mmd_cpu_model
  import mmd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  input wire logic rdata_valid,
  output mmd_bus_t cpu_bus,
  output logic sp_push,
  output logic sp_pop,
  output logic reset_n
);
  initial
  begin
    cpu_bus = '0;
    sp_push = 1'b0;
    sp_pop = 1'b0;
    reset_n = 1'b1;
  end
  task automatic put_addr(input logic [13:0] a);
    @(negedge ref_clk);
    cpu_bus <= '{addr: a, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
  endtask
  // one access, then bus idles with inverted values
  task automatic access(input logic [13:0] a, input logic rd, input logic [7:0] d,
                        output logic v, output logic [7:0] q);
    @(negedge ref_clk);
    cpu_bus <= '{addr: a, rd: rd, wr: !rd, wdata: d};
    @(negedge ref_clk);
    v = rdata_valid;
    q = rdata;
    cpu_bus <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
  endtask
  task automatic step(input logic push, input logic pop);
    @(negedge ref_clk);
    sp_push <= push;
    sp_pop <= pop;
    @(negedge ref_clk);
    sp_push <= 1'b0;
    sp_pop <= 1'b0;
  endtask
  // reset pulse, low for one cycle
  task automatic ext_reset;
    @(negedge ref_clk);
    reset_n <= 1'b0;
    @(negedge ref_clk);
    reset_n <= 1'b1;
  endtask
endmodule // mmd_cpu_model
`default_nettype wire

// File: verif/mmd_top_test.sv
// testbench for the memory map decoder
// assumes the cpu model drives bus, stack strobes and external reset
`timescale 1ns/100ps
`default_nettype none
module mmd_top_test
  import mmd_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic osc = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [7:0] pd = 8'h00;
  logic [7:0] pb = 8'h00;
  logic [7:0] pc = 8'h00;
  mmd_bus_t bus;
  logic push, pop, rst_n, valid, rom, vec, bclk, l7;
  logic [7:0] rdata, ao, aoe, bo, boe, co, coe, pu, ie;
  logic [2:0] sel;
  logic [13:0] sp;
  logic [1:0] ser;
  logic [3:0] spi;
  mmd_opt_t opts;
  int num_errors = 0;
  int checked = 0;
  mmd_top #(.PULLUP_IRQ_OPTION(8'h5a), .FIXED_OPTIONS(4'ha)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reset_n(rst_n), .oscillator_input(osc), .cpu_bus(bus), .sp_push(push), .sp_pop(pop),
    .first_bidir_port_in(pa), .second_bidir_port_in(pb), .third_bidir_port_in(pc),
    .input_only_port(pd), .region_sel(sel), .rom_sel(rom), .vector_hit(vec), .rdata(rdata),
    .rdata_valid(valid), .stack_addr(sp), .bus_clk(bclk), .first_bidir_port_out(ao),
    .first_bidir_port_oe(aoe), .second_bidir_port_out(bo), .second_bidir_port_oe(boe),
    .third_bidir_port_out(co), .third_bidir_port_oe(coe), .second_port_pullup_en(pu),
    .second_port_irq_en(ie), .async_serial_iface_pins(ser), .spi_pins(spi),
    .input_only_line_seven(l7), .options(opts));
  mmd_cpu_model i_cpu (.ref_clk(ref_clk), .rdata(rdata), .rdata_valid(valid), .cpu_bus(bus),
    .sp_push(push), .sp_pop(pop), .reset_n(rst_n));
  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask
  task automatic dec(input logic [13:0] a, input logic [2:0] s, input logic r, input logic v);
    i_cpu.put_addr(a);
    #1;
    chk({11'h000, sel, rom, vec}, {11'h000, s, r, v}, "decode");
  endtask
  task automatic t_decode;
    dec(14'h0000, 3'h1, 1'b0, 1'b0);
    dec(14'h001f, 3'h1, 1'b0, 1'b0);
    dec(14'h0020, 3'h2, 1'b1, 1'b0);
    dec(14'h004f, 3'h2, 1'b1, 1'b0);
    dec(14'h0050, 3'h3, 1'b0, 1'b0);
    dec(14'h00ff, 3'h3, 1'b0, 1'b0);
    dec(14'h0100, 3'h0, 1'b0, 1'b0);
    dec(14'h0fff, 3'h0, 1'b0, 1'b0);
    dec(14'h1000, 3'h4, 1'b1, 1'b0);
    dec(14'h3eff, 3'h4, 1'b1, 1'b0);
    dec(14'h3f00, 3'h5, 1'b0, 1'b0);
    dec(14'h3fef, 3'h5, 1'b0, 1'b0);
    dec(14'h3ff0, 3'h6, 1'b1, 1'b0);
    dec(14'h3ff3, 3'h6, 1'b1, 1'b0);
    dec(14'h3ff4, 3'h6, 1'b1, 1'b1);
    dec(14'h3fff, 3'h6, 1'b1, 1'b1);
    $display("decode test done");
  endtask
  task automatic t_ram;
    logic v;
    logic [7:0] q;
    i_cpu.access(14'h0050, 1'b0, 8'haa, v, q);
    i_cpu.access(14'h00ff, 1'b0, 8'h55, v, q);
    i_cpu.access(14'h1000, 1'b0, 8'h11, v, q);
    i_cpu.access(14'h0150, 1'b0, 8'h22, v, q);
    i_cpu.access(14'h0050, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h01aa, "ram low");
    i_cpu.access(14'h00ff, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h0155, "ram top");
    i_cpu.access(14'h0150, 1'b1, 8'h00, v, q);
    chk({15'h0, v}, 16'h0000, "unmapped read");
    $display("ram test done");
  endtask
  task automatic t_ports;
    logic v;
    logic [7:0] q;
    pa = 8'h99;
    pd = 8'hd6;
    pb = 8'h4b;
    pc = 8'he1;
    for (int i = 0; i < 3; i++)
    begin
      i_cpu.access(MMD_DDR_LO + 14'(i), 1'b0, 8'hf0, v, q);
      i_cpu.access(14'(i), 1'b0, 8'h3c, v, q);
    end
    chk({aoe, boe}, 16'hf0f0, "ddr a b");
    chk({coe, co}, 16'hf03c, "port c");
    chk({ao, bo}, 16'h3c3c, "data a b");
    i_cpu.access(14'h0000, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h0139, "port a read");
    i_cpu.access(MMD_PORTD_ADDR, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h0196, "input port read");
    chk({9'h0, l7, spi, ser}, 16'h0056, "shared lines");
    i_cpu.access(14'h0001, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h013b, "port b read");
    i_cpu.access(14'h0002, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h0131, "port c read");
    i_cpu.access(MMD_DDR_LO + 14'h0001, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h01f0, "ddr b read");
    i_cpu.access(14'h0007, 1'b1, 8'h00, v, q);
    chk({7'h0, v, q}, 16'h0100, "unused io read");
    @(negedge ref_clk);
    sys_rst = 1'b1;
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk({aoe, boe}, 16'h0000, "ddr a b reset");
    chk({coe, ao}, 16'h0000, "ddr c reset");
    i_cpu.access(MMD_DDR_LO, 1'b0, 8'hff, v, q);
    chk({aoe, 8'h00}, 16'hff00, "ddr a set");
    i_cpu.ext_reset;
    chk({aoe, 8'h00}, 16'h0000, "ext reset");
    $display("port test done");
  endtask
  task automatic t_stack;
    for (int i = 1; i < 64; i++)
    begin
      i_cpu.step(1'b1, 1'b0);
      chk({2'b00, sp}, 16'h00ff - 16'(i), "push");
    end
    i_cpu.step(1'b1, 1'b0);
    chk({2'b00, sp}, 16'h00ff, "push wrap");
    i_cpu.step(1'b0, 1'b1);
    chk({2'b00, sp}, 16'h00c0, "pop wrap");
    i_cpu.step(1'b1, 1'b1);
    chk({2'b00, sp}, 16'h00c0, "hold");
    i_cpu.step(1'b0, 1'b1);
    chk({2'b00, sp}, 16'h00c1, "pop");
    i_cpu.ext_reset;
    chk({2'b00, sp}, 16'h00ff, "stack ext reset");
    $display("stack test done");
  endtask
  task automatic t_clock;
    for (int i = 1; i < 7; i++)
    begin
      osc = 1'b1;
      repeat (4) @(negedge ref_clk);
      osc = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk({15'h0, bclk}, 16'(i % 2), "bus clock");
    end
    chk({pu, ie}, 16'h5a5a, "pullup irq");
    chk({12'h0, opts}, 16'h000a, "options");
    $display("clock test done");
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk({2'b00, sp}, 16'h00ff, "stack reset");
    chk({aoe, coe}, 16'h0000, "ddr reset");
    t_decode;
    t_ram;
    t_ports;
    t_stack;
    t_clock;
    test_done;
  end
  initial
  begin
    #20000;
    num_errors++;
    test_done;
  end
endmodule // mmd_top_test
`default_nettype wire
